//--- common/fbp_pkg.sv
/*
 fbp_pkg: pixel formats, layout options, carrier structs and constants
 for the frame-buffer pixel packer.
 assumes the configuration is driven from logic on clk_sys and held
 stable while pixels are being written.
*/
package fbp_pkg;

  typedef enum logic [2:0] {
    FBP_FMT_ARGB8888 = 3'h0,
    FBP_FMT_RGB888 = 3'h1,
    FBP_FMT_RGB565 = 3'h2,
    FBP_FMT_ARGB1555 = 3'h3,
    FBP_FMT_ARGB4444 = 3'h4,
    FBP_FMT_GRAY4 = 3'h5,
    FBP_FMT_GRAY2 = 3'h6,
    FBP_FMT_GRAY1 = 3'h7
  } fbp_format_type;

  typedef enum logic {
    FBP_SCAN_ROW = 1'b0,
    FBP_SCAN_COLUMN = 1'b1
  } fbp_scan_type;

  typedef enum logic {
    FBP_PACK_LINE = 1'b0,
    FBP_PACK_COLUMN = 1'b1
  } fbp_pack_type;

  localparam int FBP_COORD_W = 16;
  localparam int FBP_ADDR_W = 32;
  localparam int FBP_FIFO_DEPTH = 16;

  localparam logic [7:0] FBP_OPAQUE = 8'hff;
  localparam logic [7:0] FBP_GRAY4_DIV = 8'h11;
  localparam logic [7:0] FBP_GRAY2_DIV = 8'h55;
  localparam logic [7:0] FBP_GRAY1_LEVEL = 8'hff;
  localparam logic [31:0] FBP_COLOUR_RST = 32'h0000_0000;

  typedef struct packed {
    fbp_format_type pixel_format;
    fbp_scan_type frame_scan_order_option;
    fbp_pack_type pixel_byte_packing_option;
    logic [FBP_COORD_W-1:0] width;
    logic [FBP_COORD_W-1:0] height;
    logic [FBP_ADDR_W-1:0] base_addr;
  } fbp_cfg_type;

  typedef struct packed {
    logic [FBP_COORD_W-1:0] x;
    logic [FBP_COORD_W-1:0] y;
    logic [31:0] argb;
  } fbp_req_type;

  // lane i of data goes to byte address addr+i; bit_mask applies to lane 0
  typedef struct packed {
    logic [FBP_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] lane_en;
    logic [7:0] bit_mask;
  } fbp_wr_type;

  localparam int FBP_WR_W = $bits(fbp_wr_type);

endpackage : fbp_pkg

//--- rtl/fbp_packer.sv
/*
 fbp_packer: converts 32-bit colours to the selected display pixel format
 and places them in frame memory, plus a pixel-to-colour converter.
 fbp_fifo: buffer of memory writes between packer and frame memory.
 assumes a frame memory that applies lane enables and a lane-0 bit mask
 itself, so sub-byte pixels need no read-modify-write here.
*/
// Functional notes
// - sub-byte line packing, rows padded to bytes
// - sub-byte column packing, columns padded to bytes
// - first pixel in least significant bits
// - wide pixels stored row by row
// - multi-byte pixels least significant byte first
// - 24-bit pixels three bytes, 32-bit four
// - sub-byte scan order row or column
// - row scan, line packing byte coverage
// - row scan, column packing advances columns
// - column scan, line packing advances rows
// - column scan, column packing continues down
// - ARGB8888 passes colour unchanged
// - RGB888 drops alpha
// - RGB565 truncates low colour bits
// - ARGB1555 one alpha, five per colour
// - ARGB4444 nibbles, replicated on expansion
// - gray four-bit divide by 0x11
// - gray two-bit divide by 0x55
// - gray one-bit set only at 0xff

module fbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input logic clk_sys,
  input logic rstn,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0])
    || (wr_ptr_r[AW] == rd_ptr_r[AW]);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule : fbp_fifo

module fbp_packer (
  input logic clk_sys,
  input logic rstn,
  input fbp_pkg::fbp_cfg_type cfg,
  input logic req_valid,
  output logic req_ready,
  input fbp_pkg::fbp_req_type req,
  output logic mem_valid,
  input logic mem_ready,
  output fbp_pkg::fbp_wr_type mem_wr,
  input logic pix_valid,
  input logic [31:0] pix_in,
  output logic colour_valid,
  output logic [31:0] colour_out
);
  import fbp_pkg::*;

  // gray level: weighted mean (r + 2g + b) / 4, kept cheap on purpose
  function automatic logic [7:0] gray_level_of_colour(input logic [31:0] c);
    logic [9:0] sum;
    sum = 10'(c[23:16]) + {1'b0, c[15:8], 1'b0} + 10'(c[7:0]);
    return sum[9:2];
  endfunction : gray_level_of_colour

  function automatic logic [31:0] to_pixel(input logic [31:0] c,
                                           input fbp_format_type f);
    logic [7:0] g;
    g = gray_level_of_colour(c);
    case (f)
      FBP_FMT_ARGB8888: return c;
      FBP_FMT_RGB888: return {8'h00, c[23:0]};
      FBP_FMT_RGB565:
        return {16'h0000, c[23:19], c[15:10], c[7:3]};
      FBP_FMT_ARGB1555:
        return {16'h0000, c[31], c[23:19], c[15:11], c[7:3]};
      FBP_FMT_ARGB4444:
        return {16'h0000, c[31:28], c[23:20], c[15:12], c[7:4]};
      FBP_FMT_GRAY4: return 32'(g / FBP_GRAY4_DIV);
      FBP_FMT_GRAY2: return 32'(g / FBP_GRAY2_DIV);
      default: return 32'(g == FBP_GRAY1_LEVEL);
    endcase
  endfunction : to_pixel

  // replication of the gray code equals the documented multiplications
  function automatic logic [31:0] to_colour(input logic [31:0] p,
                                            input fbp_format_type f);
    case (f)
      FBP_FMT_ARGB8888: return p;
      FBP_FMT_RGB888: return {FBP_OPAQUE, p[23:0]};
      FBP_FMT_RGB565:
        return {FBP_OPAQUE, p[15:11], p[15:13], p[10:5], p[10:9],
                p[4:0], p[4:2]};
      FBP_FMT_ARGB1555:
        return {{8{p[15]}}, p[14:10], p[14:12], p[9:5], p[9:7],
                p[4:0], p[4:2]};
      FBP_FMT_ARGB4444:
        return {p[15:12], p[15:12], p[11:8], p[11:8],
                p[7:4], p[7:4], p[3:0], p[3:0]};
      FBP_FMT_GRAY4: return {FBP_OPAQUE, {6{p[3:0]}}};
      FBP_FMT_GRAY2: return {FBP_OPAQUE, {12{p[1:0]}}};
      default: return {FBP_OPAQUE, {24{p[0]}}};
    endcase
  endfunction : to_colour

  logic [31:0] pix;
  logic sub_byte;
  logic [1:0] ppb_log;
  logic [1:0] bpp_log;
  logic [2:0] ppb_mask;
  logic [31:0] bytes_per_row;
  logic [31:0] bytes_per_col;
  logic [31:0] lin;
  logic [2:0] idx;
  logic [2:0] off;
  logic [7:0] field_mask;
  logic [3:0] lanes;
  logic [31:0] wx;
  logic [31:0] wy;
  logic in_range;
  fbp_wr_type wr_nxt;
  fbp_wr_type stage_r;
  logic stage_valid_r;
  logic fifo_in_ready;
  logic take;

  always_comb
  begin
    pix = to_pixel(req.argb, cfg.pixel_format);
    sub_byte = cfg.pixel_format >= FBP_FMT_GRAY4;
    case (cfg.pixel_format)
      FBP_FMT_GRAY4: ppb_log = 2'h1;
      FBP_FMT_GRAY2: ppb_log = 2'h2;
      FBP_FMT_GRAY1: ppb_log = 2'h3;
      default: ppb_log = 2'h0;
    endcase
    case (cfg.pixel_format)
      FBP_FMT_ARGB8888: lanes = 4'hf;
      FBP_FMT_RGB888: lanes = 4'h7;
      FBP_FMT_RGB565, FBP_FMT_ARGB1555, FBP_FMT_ARGB4444: lanes = 4'h3;
      default: lanes = 4'h1;
    endcase
    bpp_log = 2'(3'h3 - 3'(ppb_log));
    ppb_mask = 3'((4'h1 << ppb_log) - 4'h1);
    wx = 32'(req.x);
    wy = 32'(req.y);
    // rounding up pads the last byte of each row or column
    bytes_per_row = 32'((17'(cfg.width) + 17'(ppb_mask)) >> ppb_log);
    bytes_per_col = 32'((17'(cfg.height) + 17'(ppb_mask)) >> ppb_log);
    lin = '0;
    idx = '0;
    if (!sub_byte)
    begin
      lin = (wy * 32'(cfg.width) + wx) * 32'(lanes[3] + lanes[2]
        + lanes[1] + lanes[0]);
    end
    else if (cfg.frame_scan_order_option == FBP_SCAN_ROW)
    begin
      if (cfg.pixel_byte_packing_option == FBP_PACK_LINE)
      begin
        lin = wy * bytes_per_row + (wx >> ppb_log);
        idx = req.x[2:0] & ppb_mask;
      end
      else
      begin
        lin = (wy >> ppb_log) * 32'(cfg.width) + wx;
        idx = req.y[2:0] & ppb_mask;
      end
    end
    else
    begin
      if (cfg.pixel_byte_packing_option == FBP_PACK_LINE)
      begin
        lin = (wx >> ppb_log) * 32'(cfg.height) + wy;
        idx = req.x[2:0] & ppb_mask;
      end
      else
      begin
        lin = wx * bytes_per_col + (wy >> ppb_log);
        idx = req.y[2:0] & ppb_mask;
      end
    end
    off = 3'(idx << bpp_log);
    field_mask = 8'((9'h001 << (4'h1 << bpp_log)) - 9'h001);
    in_range = (req.x < cfg.width) && (req.y < cfg.height);
    wr_nxt.addr = cfg.base_addr + lin;
    wr_nxt.lane_en = lanes;
    if (sub_byte)
    begin
      wr_nxt.data = {24'h000000, 8'(pix[7:0] << off)};
      wr_nxt.bit_mask = 8'(field_mask << off);
    end
    else
    begin
      wr_nxt.data = pix;
      wr_nxt.bit_mask = 8'hff;
    end
  end

  // one request taken per clock while the fifo keeps up
  assign req_ready = !stage_valid_r || fifo_in_ready;
  assign take = req_valid && req_ready;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_valid_r <= 1'b0;
      stage_r <= '0;
    end
    else if (req_ready)
    begin
      // out-of-frame pixels are accepted and dropped
      stage_valid_r <= take && in_range;
      stage_r <= wr_nxt;
    end
  end

  fbp_fifo #(
    .WIDTH(FBP_WR_W),
    .DEPTH(FBP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(stage_valid_r),
    .in_ready(fifo_in_ready),
    .in_data(stage_r),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data(mem_wr)
  );

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      colour_valid <= 1'b0;
      colour_out <= FBP_COLOUR_RST;
    end
    else
    begin
      colour_valid <= pix_valid;
      if (pix_valid)
      begin
        colour_out <= to_colour(pix_in, cfg.pixel_format);
      end
    end
  end
endmodule : fbp_packer

//--- tb/fbp_mem_model.sv
/*
 fbp_mem_model: small byte-wide frame memory behind the packer.
 assumes byte addresses below 256; stall holds off every write.
*/
module fbp_mem_model (
  input logic clk_sys,
  input logic rstn,
  input logic stall,
  input logic clr,
  input logic mem_valid,
  output logic mem_ready,
  input fbp_pkg::fbp_wr_type mem_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbp_pkg::*;
  logic [7:0] mem [0:255];
  int wr_count;
  logic [7:0] a;
  assign mem_ready = !stall;
  assign a = mem_wr.addr[7:0];
  // lane 0 of a sub-byte write merges bits, so neighbours must survive
  always @(posedge clk_sys)
  begin
    if (!rstn)
      wr_count <= 0;
    if (clr)
      foreach (mem[i]) mem[i] <= 8'h00;
    else if (mem_valid && mem_ready)
    begin
      wr_count <= wr_count + 1;
      for (int i = 0; i < 4; i++)
        if (mem_wr.lane_en[i])
          mem[8'(a + i)] <= (i == 0 && mem_wr.lane_en == 4'h1) ?
            (mem[a] & ~mem_wr.bit_mask) | (mem_wr.data[7:0] &
            mem_wr.bit_mask) : mem_wr.data[8*i+:8];
    end
  end
endmodule : fbp_mem_model

//--- tb/fbp_packer_monitor.sv
/*
 fbp_packer_monitor: port assertions for the pixel packer.
 assumes cfg is steady while writes are in flight.
*/
module fbp_packer_monitor (
  input logic clk_sys,
  input logic rstn,
  input fbp_pkg::fbp_cfg_type cfg,
  input logic pix_valid,
  input logic [31:0] pix_in,
  input logic colour_valid,
  input logic [31:0] colour_out,
  input logic mem_valid,
  input logic mem_ready,
  input fbp_pkg::fbp_wr_type mem_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbp_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  fbp_format_type f;
  assign f = cfg.pixel_format;
  sequence pix_s;
    pix_valid;
  endsequence
  sequence stall_s;
    mem_valid && !mem_ready;
  endsequence
  colour_pulse_a:
    assert property (pix_s |=> colour_valid) else $error("no colour");
  colour_idle_a:
    assert property (!pix_valid |=> !colour_valid) else $error("stray");
  argb_pass_a:
    assert property (pix_s ##0 f == FBP_FMT_ARGB8888 |=>
      colour_out == $past(pix_in)) else $error("argb changed");
  gray_expand_a:
    assert property (pix_s ##0 f == FBP_FMT_GRAY4 |=>
      colour_out == {8'hff, {6{$past(pix_in[3:0])}}}) else $error("gray");
  wr_hold_a:
    assert property (stall_s |=> mem_valid && $stable(mem_wr))
      else $error("write dropped");
  lane_wide_a:
    assert property (mem_valid && f == FBP_FMT_ARGB8888 |->
      mem_wr.lane_en == 4'hf) else $error("lanes 32");
  lane_rgb_a:
    assert property (mem_valid && f == FBP_FMT_RGB888 |->
      mem_wr.lane_en == 4'h7) else $error("lanes 24");
  sub_mask_a:
    assert property (mem_valid && f == FBP_FMT_GRAY4 |->
      mem_wr.lane_en == 4'h1 && $countones(mem_wr.bit_mask) == 4)
      else $error("sub mask");
endmodule : fbp_packer_monitor

bind fbp_packer fbp_packer_monitor fbp_packer_monitor_inst (
  .clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .pix_valid(pix_valid),
  .pix_in(pix_in), .colour_valid(colour_valid), .colour_out(colour_out),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_wr(mem_wr));

//--- tb/fbp_packer_tb_top.sv
/*
 fbp_packer_tb_top: self-checking bench for the pixel packer.
 assumes fbp_mem_model as frame memory and the bound monitor.
*/
module fbp_packer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fbp_pkg::*;
  logic clk_sys, rstn, req_valid, req_ready, mem_valid, mem_ready;
  logic pix_valid, colour_valid, stall, clr;
  logic [31:0] pix_in, colour_out;
  fbp_cfg_type cfg;
  fbp_req_type req;
  fbp_wr_type mem_wr;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  localparam logic [31:0] W = 32'hffffffff;
  localparam logic [31:0] G = 32'h00808080;
  fbp_packer fbp_packer_inst (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_wr(mem_wr),
    .pix_valid(pix_valid), .pix_in(pix_in), .colour_valid(colour_valid),
    .colour_out(colour_out));
  fbp_mem_model fbp_mem_model_inst (.clk_sys(clk_sys), .rstn(rstn),
    .stall(stall), .clr(clr), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_wr(mem_wr));
  task automatic stop_test;
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] rd(input int a, n);
    logic [31:0] g;
    g = '0;
    for (int i = 0; i < n; i++)
      g[8*i+:8] = fbp_mem_model_inst.mem[a+i];
    return g;
  endfunction : rd
  // scan and packing are set together with the format, never mid-traffic
  task automatic setc(input fbp_format_type f, input logic [1:0] l);
    cfg = '{f, fbp_scan_type'(l[1]), fbp_pack_type'(l[0]), 16'd10, 16'd10,
      32'h0};
    clr = 1;
    @(negedge clk_sys);
    clr = 0;
  endtask : setc
  task automatic wr(input logic [15:0] x, y, input logic [31:0] c);
    int n;
    n = 0;
    req = '{x, y, c};
    req_valid = 1;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("req ready", 32'h1, {31'h0, req_ready});
    @(negedge clk_sys);
  endtask : wr
  task automatic drain;
    int n;
    n = 0;
    repeat (3) @(negedge clk_sys);
    while (mem_valid !== 1'b0 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("mem idle", 32'h0, {31'h0, mem_valid});
  endtask : drain
  task automatic wide(input fbp_format_type f, input logic [15:0] x, y,
    input logic [31:0] c, input int a, n, input logic [31:0] e);
    setc(f, 2'h0);
    wr(x, y, c);
    req_valid = 0;
    drain;
    chk("wide pixel", e, rd(a, n));
  endtask : wide
  task automatic sub(input fbp_format_type f, input logic [1:0] l,
    input logic [15:0] x, y, input logic [31:0] c, input int a,
    input logic [7:0] e);
    setc(f, l);
    wr(x, y, c);
    req_valid = 0;
    drain;
    chk("packed byte", {24'h0, e}, rd(a, 1));
  endtask : sub
  // pix_valid stays high between calls, so conversions run back to back
  task automatic conv(input fbp_format_type f, input logic [31:0] p, e);
    cfg.pixel_format = f;
    pix_valid = 1;
    pix_in = p;
    @(negedge clk_sys);
    chk("colour", e, colour_out);
    chk("colour valid", 32'h1, {31'h0, colour_valid});
  endtask : conv
  task automatic fill;
    int n, w0;
    setc(FBP_FMT_ARGB8888, 2'h0);
    w0 = fbp_mem_model_inst.wr_count;
    stall = 1;
    n = 0;
    while (req_ready === 1'b1 && n < 30)
    begin
      req = '{16'(n % 10), 16'(n / 10), 32'(n)};
      req_valid = 1;
      n++;
      @(negedge clk_sys);
    end
    req_valid = 0;
    stall = 0;
    chk("accepted", FBP_FIFO_DEPTH + 1, n);
    drain;
    chk("writes", n, fbp_mem_model_inst.wr_count - w0);
    chk("last pixel", 32'h10, rd(64, 4));
    wr(16'd10, 16'd0, W);
    req_valid = 0;
    drain;
    chk("outside", n, fbp_mem_model_inst.wr_count - w0);
  endtask : fill
  initial
  begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      stop_test;
    end
  end
  initial
  begin
    rstn = 0;
    stall = 0;
    clr = 0;
    req_valid = 0;
    pix_valid = 0;
    pix_in = '0;
    req = '0;
    cfg = '0;
    // counting rising edges avoids the start-up edge of the clock variable
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset flags", 32'h1, {29'h0, mem_valid, colour_valid, req_ready});
    chk("reset colour", 32'h0, colour_out);
    rstn = 1;
    wide(FBP_FMT_ARGB8888, 1, 1, 32'h11223344, 44, 4, 32'h11223344);
    wide(FBP_FMT_RGB888, 1, 0, 32'h11223344, 3, 3, 32'h223344);
    wide(FBP_FMT_RGB565, 2, 0, 32'hff804020, 4, 2, 32'h8204);
    wide(FBP_FMT_ARGB1555, 3, 0, 32'hff804020, 6, 2, 32'hc104);
    wide(FBP_FMT_ARGB4444, 4, 0, 32'hff804020, 8, 2, 32'hf842);
    sub(FBP_FMT_GRAY1, 2'h0, 9, 0, W, 1, 8'h02);
    sub(FBP_FMT_GRAY1, 2'h0, 2, 1, W, 2, 8'h04);
    sub(FBP_FMT_GRAY2, 2'h1, 3, 5, W, 13, 8'h0c);
    sub(FBP_FMT_GRAY4, 2'h2, 3, 2, W, 12, 8'hf0);
    sub(FBP_FMT_GRAY1, 2'h3, 0, 9, W, 1, 8'h02);
    sub(FBP_FMT_GRAY1, 2'h3, 1, 0, W, 2, 8'h01);
    sub(FBP_FMT_GRAY4, 2'h0, 0, 0, G, 0, 8'h07);
    sub(FBP_FMT_GRAY2, 2'h0, 4, 0, G, 1, 8'h01);
    sub(FBP_FMT_GRAY1, 2'h0, 1, 0, G, 0, 8'h00);
    conv(FBP_FMT_ARGB8888, 32'h12345678, 32'h12345678);
    conv(FBP_FMT_RGB888, 32'h123456, 32'hff123456);
    conv(FBP_FMT_RGB565, 32'h8204, 32'hff844121);
    conv(FBP_FMT_ARGB1555, 32'h8000, 32'hff000000);
    conv(FBP_FMT_ARGB4444, 32'h0f84, 32'h00ff8844);
    conv(FBP_FMT_GRAY4, 32'h5, 32'hff555555);
    conv(FBP_FMT_GRAY2, 32'h2, 32'hffaaaaaa);
    conv(FBP_FMT_GRAY1, 32'h1, 32'hffffffff);
    pix_valid = 0;
    fill;
    stop_test;
  end
endmodule : fbp_packer_tb_top
